// file: inc/motor_map.vh
// Purpose: constants for the motor startup, protection and tachometer logic
// Assumes: 20 MHz clock; speed command digitised to 7 bits at 0.1 V per code
// Notes:   definitions only
`ifndef MOTOR_MAP_VH
`define MOTOR_MAP_VH

// ----------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------
`define CLOCK_KHZ 20000
`define PRECHARGE_TIME_US 9000
`define FAULT_HOLD_TIME_US 15000
`define LOCK_TIME_US 1000000
`define SENSOR_FILTER_TIME_US 2
`define PRECHARGE_CYCLES ((`PRECHARGE_TIME_US * `CLOCK_KHZ) / 1000)
`define FAULT_HOLD_CYCLES ((`FAULT_HOLD_TIME_US * `CLOCK_KHZ) / 1000)
`define LOCK_CYCLES ((`LOCK_TIME_US * `CLOCK_KHZ) / 1000)
`define SENSOR_FILTER_CYCLES ((`SENSOR_FILTER_TIME_US * `CLOCK_KHZ) / 1000)

// ----------------------------------------------------------------
// speed command levels, 7-bit codes; pwm steps, prescale and charge width
// ----------------------------------------------------------------
`define SPEED_CODE_ON 7'h0a
`define SPEED_CODE_CONTROL 7'h15
`define SPEED_CODE_FULL 7'h36
`define PWM_STEPS 33
`define PWM_PRESCALE 20
`define CHARGE_WIDTH 6'h04

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_STATUS 5'h00
`define REG_EVENT 5'h04
`define REG_EVENT_MASK 5'h08
`define REG_OC_LEVELS 5'h0c
`define REG_SPEED 5'h10

// ----------------------------------------------------------------
// event bits, reset values
// ----------------------------------------------------------------
`define EV_OC_TRIP 0
`define EV_LOCK 1
`define EV_SENSOR 2
`define EV_CUR_LIMIT 3
`define EV_RUN 4
`define EV_WIDTH 5
`define OC_LIMIT_RESET 8'h80
`define OC_TRIP_RESET 8'hc0
`define EVENT_MASK_RESET 5'h00

`endif

// file: rtl/hall_tach.v
// Purpose: position sensor decode, validity filter and tachometer toggle
// Assumes: comparator inputs synchronous to i_clock
// Notes:   tach output resets low, as the pin pull-down holds it
module hall_tach #(
    parameter FILTER_CYCLES = 40
) (
    // clock and reset
    input wire i_clock,
    input wire i_reset_n,
    // sensor comparators
    input wire i_phase_u_sensor_pos,
    input wire i_phase_u_sensor_neg,
    input wire i_phase_v_sensor_pos,
    input wire i_phase_v_sensor_neg,
    input wire i_phase_w_sensor_pos,
    input wire i_phase_w_sensor_neg,
    // settings
    input wire i_rate_one,
    // results
    output reg [2:0] o_hall_state,
    output wire o_hall_change,
    output reg o_sensor_bad,
    output reg o_tach_pulse_out
);
    wire [2:0] pos_bits = {i_phase_w_sensor_pos, i_phase_v_sensor_pos, i_phase_u_sensor_pos};
    wire [2:0] neg_bits = {i_phase_w_sensor_neg, i_phase_v_sensor_neg, i_phase_u_sensor_neg};
    wire [2:0] hall_now = pos_bits & ~neg_bits;
    // a pair that agrees with itself, or an all-equal code, is not a real position
    wire invalid_now = (|(~(pos_bits ^ neg_bits))) || (hall_now == 3'b000) || (hall_now == 3'b111);
    reg [15:0] bad_count;
    wire [2:0] changed = hall_now ^ o_hall_state;

    assign o_hall_change = (|changed) && !invalid_now;

    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_hall_state <= 3'b000;
            o_tach_pulse_out <= 1'b0;
            bad_count <= 16'h0000;
            o_sensor_bad <= 1'b0;
        end else begin
            // abnormal code must persist to count as a fault
            if (!invalid_now) begin
                bad_count <= 16'h0000;
                o_sensor_bad <= 1'b0;
            end else if (bad_count >= FILTER_CYCLES[15:0]) begin
                o_sensor_bad <= 1'b1;
            end else begin
                bad_count <= bad_count + 16'h0001;
            end
            if (o_hall_change) begin
                o_hall_state <= hall_now;
                // three pulses: every phase edge; one pulse: U edges only
                if ((!i_rate_one || changed[0]) && (o_hall_state != 3'b000)) begin
                    o_tach_pulse_out <= ~o_tach_pulse_out;
                end
            end
        end
    end
endmodule // hall_tach

// file: rtl/motor_startup_config_and_tach.v
// Purpose: startup strap capture, speed-level gating, protection and fault
//          output, tachometer, and an Avalon-MM register slave
// Assumes: reset is the logic-supply undervoltage condition; speed command and
//          overcurrent sense arrive as digitised codes
// Notes:   answers every bus access one cycle after it is presented
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`include "motor_map.vh"

// Functional notes
// - start after supply good; capture the three straps
// - lock strap low enables lock protection
// - direction strap low forward, high reverse
// - rate strap low three, high one pulse
// - tach toggles on selected sensor edges; resets low
// - sense level picks current limit or shutdown
// - outputs off while command below on level
// - between on and control levels: precharge only, full drive if already running
// - invalid sensor signals flag sensor fault
// - 7-bit command sets duty, full at top
// - jump into control range: timed precharge first
module motor_startup_config_and_tach #(
    parameter PRECHARGE_CYCLES = `PRECHARGE_CYCLES,
    parameter FAULT_HOLD_CYCLES = `FAULT_HOLD_CYCLES,
    parameter LOCK_CYCLES = `LOCK_CYCLES,
    parameter PWM_PRESCALE = `PWM_PRESCALE
) (
    // clock and reset
    input wire i_clock,
    input wire i_reset_n,
    // straps
    input wire i_lock_guard_select,
    input wire i_rotation_dir_select,
    input wire i_tach_rate_select,
    // position sensor comparators
    input wire i_phase_u_sensor_pos,
    input wire i_phase_u_sensor_neg,
    input wire i_phase_v_sensor_pos,
    input wire i_phase_v_sensor_neg,
    input wire i_phase_w_sensor_pos,
    input wire i_phase_w_sensor_neg,
    // analog front end codes
    input wire [6:0] i_speed_command_in,
    input wire [7:0] i_overcurrent_sense,
    // drive and status outputs
    output reg o_drive_pwm,
    output reg o_precharge_low,
    output reg o_current_limit,
    output reg o_fault_out,
    output wire o_tach_pulse_out,
    output reg o_dir_reverse,
    output reg o_lock_guard_on,
    output reg o_tach_rate_one,
    output wire [2:0] o_hall_state,
    // avalon-mm slave
    input wire [4:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // interrupt
    output wire o_irq
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [4:0] ST_CAPTURE = 5'b00001;
    localparam [4:0] ST_OFF = 5'b00010;
    localparam [4:0] ST_CHARGE = 5'b00100;
    localparam [4:0] ST_TIMED = 5'b01000;
    localparam [4:0] ST_RUN = 5'b10000;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function [1:0] speed_zone;
        input [6:0] code;
        begin
            if (code < `SPEED_CODE_ON) begin
                speed_zone = 2'd0;
            end else if (code < `SPEED_CODE_CONTROL) begin
                speed_zone = 2'd1;
            end else begin
                speed_zone = 2'd2;
            end
        end
    endfunction

    function [31:0] merge_bytes;
        input [31:0] old_value;
        input [31:0] new_value;
        input [3:0] lanes;
        integer k;
        begin
            merge_bytes = old_value;
            for (k = 0; k < 4; k = k + 1) begin
                if (lanes[k]) begin
                    merge_bytes[k * 8 +: 8] = new_value[k * 8 +: 8];
                end
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg [4:0] state;
    reg [4:0] next_state;
    reg [17:0] timed_count;
    reg [24:0] lock_count;
    reg lock_fault;
    reg [18:0] hold_count;
    reg [7:0] oc_limit;
    reg [7:0] oc_trip;
    reg [`EV_WIDTH-1:0] event_flags;
    reg [`EV_WIDTH-1:0] event_mask;
    reg bus_ack;
    reg limit_prev;
    reg sensor_prev;
    reg [5:0] pwm_width;
    wire hall_change;
    wire sensor_bad;
    wire pwm_on;
    wire [1:0] zone = speed_zone(i_speed_command_in);
    wire oc_trip_now = (i_overcurrent_sense >= oc_trip);
    wire oc_limit_now = (i_overcurrent_sense >= oc_limit) && !oc_trip_now;
    wire protect_active = oc_trip_now || lock_fault || sensor_bad;
    wire shutdown = protect_active || o_fault_out;
    wire bus_take = (i_avs_read || i_avs_write) && bus_ack;
    wire event_write = bus_take && i_avs_write && (i_avs_address == `REG_EVENT);
    wire [`EV_WIDTH-1:0] event_clear = event_write ? i_avs_writedata[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};
    wire [6:0] speed_over = i_speed_command_in - `SPEED_CODE_CONTROL;
    wire [31:0] mask_merged = merge_bytes({27'h000_0000, event_mask}, i_avs_writedata, i_avs_byteenable);
    wire [31:0] levels_merged = merge_bytes({16'h0000, oc_trip, oc_limit}, i_avs_writedata, i_avs_byteenable);
    wire [`EV_WIDTH-1:0] event_set;

    // ----------------------------------------------------------------
    // sensor decode and tachometer
    // ----------------------------------------------------------------
    hall_tach #(
        .FILTER_CYCLES(`SENSOR_FILTER_CYCLES)
    ) u_hall_tach (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_phase_u_sensor_pos(i_phase_u_sensor_pos),
        .i_phase_u_sensor_neg(i_phase_u_sensor_neg),
        .i_phase_v_sensor_pos(i_phase_v_sensor_pos),
        .i_phase_v_sensor_neg(i_phase_v_sensor_neg),
        .i_phase_w_sensor_pos(i_phase_w_sensor_pos),
        .i_phase_w_sensor_neg(i_phase_w_sensor_neg),
        .i_rate_one(o_tach_rate_one),
        .o_hall_state(o_hall_state),
        .o_hall_change(hall_change),
        .o_sensor_bad(sensor_bad),
        .o_tach_pulse_out(o_tach_pulse_out)
    );

    // ----------------------------------------------------------------
    // pwm carrier
    // ----------------------------------------------------------------
    pwm_carrier #(
        .PRESCALE(PWM_PRESCALE),
        .STEPS(`PWM_STEPS)
    ) u_pwm_carrier (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_width(pwm_width),
        .o_on(pwm_on),
        .o_period_start()
    );

    // duty rises with the code from the control level; codes past the full level or below the control level saturate
    always @* begin
        pwm_width = `CHARGE_WIDTH;
        if (state == ST_RUN) begin
            pwm_width = (i_speed_command_in >= `SPEED_CODE_FULL) ? 6'd`PWM_STEPS : speed_over[5:0];
        end
    end

    // ----------------------------------------------------------------
    // startup sequence
    // ----------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_CAPTURE: next_state = ST_OFF;
            ST_OFF: begin
                if (zone == 2'd1) begin
                    next_state = ST_CHARGE;
                end else if (zone == 2'd2) begin
                    next_state = ST_TIMED;
                end
            end
            ST_CHARGE: begin
                if (zone == 2'd0) begin
                    next_state = ST_OFF;
                end else if (zone == 2'd2) begin
                    next_state = ST_RUN;
                end
            end
            ST_TIMED: begin
                if (zone == 2'd0) begin
                    next_state = ST_OFF;
                end else if (timed_count >= PRECHARGE_CYCLES[17:0] - 18'd1) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (zone == 2'd0) begin
                    next_state = ST_OFF;
                end
            end
            default: next_state = ST_CAPTURE;
        endcase
    end

    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            state <= ST_CAPTURE;
            timed_count <= 18'd0;
            o_dir_reverse <= 1'b0;
            o_lock_guard_on <= 1'b0;
            o_tach_rate_one <= 1'b0;
        end else begin
            state <= next_state;
            timed_count <= (state == ST_TIMED) ? timed_count + 18'd1 : 18'd0;
            // straps sampled once after supply good, then frozen
            if (state == ST_CAPTURE) begin
                o_lock_guard_on <= !i_lock_guard_select;
                o_dir_reverse <= i_rotation_dir_select;
                o_tach_rate_one <= i_tach_rate_select;
            end
        end
    end

    // ----------------------------------------------------------------
    // protection and outputs
    // ----------------------------------------------------------------
    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            lock_count <= 25'd0;
            lock_fault <= 1'b0;
            hold_count <= FAULT_HOLD_CYCLES[18:0];
            o_fault_out <= 1'b1;
            o_current_limit <= 1'b0;
            o_drive_pwm <= 1'b0;
            o_precharge_low <= 1'b0;
        end else begin
            // lock: no sensor edge for the lock time while running
            if (state != ST_RUN || hall_change || !o_lock_guard_on) begin
                lock_count <= 25'd0;
            end else if (lock_count >= LOCK_CYCLES[24:0] - 25'd1) begin
                lock_fault <= 1'b1;
            end else begin
                lock_count <= lock_count + 25'd1;
            end
            // a lock clears only by a restart from the off level
            if (state == ST_OFF) begin
                lock_fault <= 1'b0;
            end
            // fault stays out for the hold time after the last cause
            if (protect_active) begin
                hold_count <= FAULT_HOLD_CYCLES[18:0];
                o_fault_out <= 1'b1;
            end else if (hold_count != 19'd0) begin
                hold_count <= hold_count - 19'd1;
            end else begin
                o_fault_out <= 1'b0;
            end
            o_current_limit <= oc_limit_now;
            // drive stops for the hold time, giving the host room to back off
            o_drive_pwm <= (state == ST_RUN) && pwm_on && !oc_limit_now && !shutdown;
            o_precharge_low <= ((state == ST_CHARGE) || (state == ST_TIMED)) && pwm_on && !shutdown;
        end
    end

    // ----------------------------------------------------------------
    // events and interrupt
    // ----------------------------------------------------------------
    assign event_set[`EV_OC_TRIP] = oc_trip_now;
    assign event_set[`EV_LOCK] = lock_fault;
    assign event_set[`EV_SENSOR] = sensor_bad && !sensor_prev;
    assign event_set[`EV_CUR_LIMIT] = oc_limit_now && !limit_prev;
    assign event_set[`EV_RUN] = (state != ST_RUN) && (next_state == ST_RUN);
    assign o_irq = |(event_flags & event_mask);

    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            event_flags <= {`EV_WIDTH{1'b0}};
            limit_prev <= 1'b0;
            sensor_prev <= 1'b0;
        end else begin
            limit_prev <= oc_limit_now;
            sensor_prev <= sensor_bad;
            // a new event wins over a simultaneous clear
            event_flags <= (event_flags & ~event_clear) | event_set;
        end
    end

    // ----------------------------------------------------------------
    // avalon-mm slave
    // ----------------------------------------------------------------
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !bus_ack;

    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            bus_ack <= 1'b0;
            o_avs_readdata <= 32'h0000_0000;
            event_mask <= `EVENT_MASK_RESET;
            oc_limit <= `OC_LIMIT_RESET;
            oc_trip <= `OC_TRIP_RESET;
        end else begin
            bus_ack <= (i_avs_read || i_avs_write) && !bus_ack;
            if (i_avs_read && !bus_ack) begin
                case (i_avs_address)
                    `REG_STATUS: o_avs_readdata <= {17'h0_0000, o_hall_state, sensor_bad, lock_fault,
                        o_fault_out, o_tach_rate_one, o_dir_reverse, o_lock_guard_on, state, o_current_limit};
                    `REG_EVENT: o_avs_readdata <= {27'h000_0000, event_flags};
                    `REG_EVENT_MASK: o_avs_readdata <= {27'h000_0000, event_mask};
                    `REG_OC_LEVELS: o_avs_readdata <= {16'h0000, oc_trip, oc_limit};
                    `REG_SPEED: o_avs_readdata <= {23'h00_0000, pwm_width, i_speed_command_in[2:0]};
                    default: o_avs_readdata <= 32'h0000_0000;
                endcase
            end
            if (bus_take && i_avs_write) begin
                case (i_avs_address)
                    `REG_EVENT_MASK: event_mask <= mask_merged[`EV_WIDTH-1:0];
                    `REG_OC_LEVELS: {oc_trip, oc_limit} <= levels_merged[15:0];
                    default: ;
                endcase
            end
        end
    end
endmodule // motor_startup_config_and_tach

// file: rtl/pwm_carrier.v
// Purpose: pwm carrier with prescaled step enable and width compare
// Assumes: width at or above STEPS means full duty
// Notes:   o_period_start pulses once per carrier period
module pwm_carrier #(
    parameter PRESCALE = 20,
    parameter STEPS = 33
) (
    // clock and reset
    input wire i_clock,
    input wire i_reset_n,
    // width in carrier steps
    input wire [5:0] i_width,
    // carrier outputs
    output wire o_on,
    output wire o_period_start
);
    reg [7:0] pre_count;
    reg [5:0] step;
    wire step_en = (pre_count == PRESCALE[7:0] - 8'h01);

    assign o_period_start = step_en && (step == 6'h00);
    assign o_on = (i_width >= STEPS[5:0]) || (step < i_width);

    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            pre_count <= 8'h00;
            step <= 6'h00;
        end else begin
            pre_count <= step_en ? 8'h00 : pre_count + 8'h01;
            if (step_en) begin
                step <= (step == STEPS[5:0] - 6'h01) ? 6'h00 : step + 6'h01;
            end
        end
    end
endmodule // pwm_carrier

// file: test/host_model.sv
// Purpose: host that drives the speed command and counts tach edges
// Assumes: reacts to fault one cycle later
// Notes:   counts every tach edge it sees
module host_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // from the driver
    input wire logic i_fault_out,
    input wire logic i_tach_pulse_out,
    // host intent and results
    input wire logic [6:0] i_want,
    output logic [6:0] o_speed_command_in,
    output int o_tach_edges
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tach_seen = 1'b0;
    initial o_speed_command_in = 7'h00;
    always @(posedge i_clock) begin
        tach_seen <= i_tach_pulse_out;
        if (!i_reset_n) begin
            o_tach_edges <= 0;
        end else if (tach_seen != i_tach_pulse_out) begin
            o_tach_edges <= o_tach_edges + 1;
        end
        o_speed_command_in <= i_fault_out ? 7'h00 : i_want;
    end
endmodule // host_model

// file: test/motor_checks_properties.sv
// Purpose: port assertions for the motor startup block
// Assumes: one clock, synchronous active-low reset, reset trip levels
// Notes:   bound to the top module at the foot of this file
module motor_checks (
    // inputs
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_lock_guard_select,
    input wire logic i_rotation_dir_select,
    input wire logic i_tach_rate_select,
    input wire logic [6:0] i_speed_command_in,
    input wire logic [7:0] i_overcurrent_sense,
    // outputs
    input wire logic o_drive_pwm,
    input wire logic o_precharge_low,
    input wire logic o_current_limit,
    input wire logic o_fault_out,
    input wire logic o_dir_reverse,
    input wire logic o_lock_guard_on,
    input wire logic o_tach_rate_one
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    // state change plus output register: two edges of slack
    sequence low_cmd;
        (i_speed_command_in < 7'h0a) [*3];
    endsequence
    sequence trip_seen;
        i_overcurrent_sense >= 8'hc0;
    endsequence
    a_fault_at_start: assert property ($rose(i_reset_n) |-> o_fault_out)
        else $error("fault low at start");
    a_strap_capture: assert property ($rose(i_reset_n) |=> o_dir_reverse == $past(i_rotation_dir_select)
        && o_lock_guard_on == !$past(i_lock_guard_select) && o_tach_rate_one == $past(i_tach_rate_select))
        else $error("straps not captured");
    a_strap_hold: assert property ($past(i_reset_n, 2) |-> $stable({o_dir_reverse, o_lock_guard_on, o_tach_rate_one}))
        else $error("settings moved");
    a_off_low: assert property (low_cmd |-> !o_drive_pwm && !o_precharge_low)
        else $error("output on at low command");
    a_no_overlap: assert property (!(o_drive_pwm && o_precharge_low))
        else $error("drive during precharge");
    a_trip_fault: assert property (trip_seen |=> o_fault_out)
        else $error("no fault on trip");
    a_limit_band: assert property ($past(i_reset_n) |->
        o_current_limit == ($past(i_overcurrent_sense) inside {[8'h80:8'hbf]}))
        else $error("limit level wrong");
    a_fault_hold: assert property ($rose(o_fault_out) |-> o_fault_out [*8])
        else $error("fault too short");
    a_fault_quiet: assert property (o_fault_out && $past(o_fault_out) |-> !o_drive_pwm)
        else $error("drive during fault");
endmodule // motor_checks

bind motor_startup_config_and_tach motor_checks motor_checks_i (.*);

// file: test/tb_top.sv
// Purpose: self-checking bench for the motor startup block
// Assumes: shortened counts: precharge 50, hold 40, carrier step 2
// Notes:   seeded random straps, codes and sense levels
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] straps = 3'b000;
    logic [2:0] hall = 3'b101;
    logic hall_bad = 1'b0;
    logic [6:0] want = 7'h00;
    logic [7:0] sense = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] q;
    logic [2:0] ring [6] = '{3'b001, 3'b011, 3'b010, 3'b110, 3'b100, 3'b101};
    int codes [5] = '{30, 45, 54, 60, 0};
    wire [6:0] cmd;
    wire [31:0] rdata;
    wire waitreq, irq, drive, charge, limit, fault, tach, dir_q, lock_q, rate_q;
    wire [2:0] hall_q;
    int tach_edges;
    int n;
    int bad_count = 0;
    int comparisons = 0;
    always #25 i_clock = ~i_clock;
    motor_startup_config_and_tach #(.PRECHARGE_CYCLES(50), .FAULT_HOLD_CYCLES(40), .LOCK_CYCLES(200),
        .PWM_PRESCALE(2)) motor_startup_config_and_tach_i (.i_clock(i_clock), .i_reset_n(rst_n),
        .i_lock_guard_select(straps[2]), .i_rotation_dir_select(straps[1]), .i_tach_rate_select(straps[0]),
        .i_phase_u_sensor_pos(hall[0]), .i_phase_u_sensor_neg(hall_bad ~^ hall[0]),
        .i_phase_v_sensor_pos(hall[1]), .i_phase_v_sensor_neg(hall_bad ~^ hall[1]),
        .i_phase_w_sensor_pos(hall[2]), .i_phase_w_sensor_neg(hall_bad ~^ hall[2]),
        .i_speed_command_in(cmd), .i_overcurrent_sense(sense), .o_drive_pwm(drive), .o_precharge_low(charge),
        .o_current_limit(limit), .o_fault_out(fault), .o_tach_pulse_out(tach), .o_dir_reverse(dir_q),
        .o_lock_guard_on(lock_q), .o_tach_rate_one(rate_q), .o_hall_state(hall_q), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_irq(irq));
    host_model host_model_i (.i_clock(i_clock), .i_reset_n(rst_n), .i_fault_out(fault),
        .i_tach_pulse_out(tach), .i_want(want), .o_speed_command_in(cmd), .o_tach_edges(tach_edges));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic ran_out;
        $display("unexpected at %0t: wait ran out", $time);
        bad_count++;
        conclude();
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge i_clock);
    endtask
    function automatic logic pick(input int k);
        return k == 0 ? fault : k == 1 ? drive : k == 2 ? charge : waitreq;
    endfunction
    task automatic await(input int k, input logic v, input int lim);
        for (n = 0; pick(k) !== v; n++) begin
            if (n == lim) ran_out();
            @(negedge i_clock);
        end
    endtask
    task automatic count_hi(input int k, input int sel);
        n = 0;
        repeat (k) begin
            @(negedge i_clock);
            n += pick(sel);
        end
    endtask
    // held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clock);
        {rd, wr, addr, wdata} <= {!w, w, a, d};
        @(negedge i_clock);
        await(3, 1'b0, 20);
        q = rdata;
        @(posedge i_clock);
        {rd, wr} <= 2'b00;
    endtask
    function automatic int duty(input int code);
        return code >= 54 ? 660 : 20 * (code - 21);
    endfunction
    function automatic int tach_exp(input logic one);
        int i, c;
        c = 0;
        for (i = 0; i < 12; i++) begin
            c += one ? int'(ring[i % 6][0] != ring[(i + 5) % 6][0]) : 1;
        end
        return c;
    endfunction
    task automatic spin(input logic one);
        int e, i;
        e = tach_edges;
        for (i = 0; i < 12; i++) begin
            tick(10);
            hall <= ring[i % 6];
        end
        tick(5);
        check(tach_edges - e, tach_exp(one));
        check(hall_q, ring[5]);
    endtask
    // straps flipped after capture: must be ignored
    task automatic power_up(input logic [2:0] s);
        tick(1);
        rst_n <= 1'b0;
        straps <= s;
        tick(10);
        rst_n <= 1'b1;
        tick(1);
        straps <= ~s;
        tick(3);
        @(negedge i_clock);
        check({lock_q, dir_q, rate_q}, {~s[2], s[1:0]});
        check(fault, 1'b1);
        bus(1'b0, 5'h00, 32'h0);
        check(q[8:6], {s[0], s[1], ~s[2]});
    endtask
    initial begin
        logic [2:0] s;
        void'($urandom(6));
        s = $urandom;
        codes[4] = 21 + $urandom % 33;
        power_up(s);
        power_up(~s);
        power_up(3'b100);
        await(0, 1'b0, 200);
        check(n > 30, 1'b1);
        bus(1'b1, 5'h08, 32'h0000_0010);
        bus(1'b0, 5'h08, 32'h0);
        check(q, 32'h0000_0010);
        bus(1'b0, 5'h14, 32'h0);
        check(q, 32'h0000_0000);
        want <= 7'h05;
        tick(20);
        want <= 7'h0f;
        count_hi(300, 2);
        check(n > 0, 1'b1);
        count_hi(100, 1);
        check(n, 0);
        tick(1);
        want <= 7'h00;
        tick(10);
        want <= 7'h28;
        await(1, 1'b1, 300);
        check(n >= 50, 1'b1);
        check(irq, 1'b1);
        bus(1'b1, 5'h04, 32'h0000_0010);
        @(negedge i_clock);
        check(irq, 1'b0);
        foreach (codes[i]) begin
            tick(1);
            want <= codes[i][6:0];
            tick(70);
            count_hi(660, 1);
            check(n, duty(codes[i]));
        end
        spin(1'b0);
        tick(1);
        sense <= 8'h80 + 8'($urandom % 64);
        tick(3);
        @(negedge i_clock);
        check(limit, 1'b1);
        tick(1);
        sense <= 8'hc8;
        await(0, 1'b1, 5);
        @(negedge i_clock);
        check(cmd, 7'h00);
        tick(1);
        sense <= 8'h00;
        await(0, 1'b0, 200);
        tick(1);
        hall_bad <= 1'b1;
        await(0, 1'b1, 100);
        check(n >= 40, 1'b1);
        tick(1);
        hall_bad <= 1'b0;
        await(0, 1'b0, 200);
        power_up(3'b001);
        spin(1'b1);
        await(0, 1'b1, 400);
        conclude();
    end
    initial #5000000 ran_out();
endmodule // tb_top
